// File: core/event_counter.sv
`timescale 1ns/1ps
module event_counter
    import perf_monitor_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_gate_open,
    input wire logic i_event,
    input wire logic i_clear,
    input wire logic i_load,
    input wire logic [CNT_W-1:0] i_load_value,
    output logic [CNT_W-1:0] o_count,
    output logic o_wrap
);
    // Wrap when an increment meets an all-ones count
    assign o_wrap = i_gate_open && i_event && !i_clear && !i_load &&
                    (o_count == {CNT_W{1'b1}});

    // Count holds while gated, except on clear; clear beats load beats increment
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_count <= COUNT_RST;
        end else if (i_clear) begin
            o_count <= COUNT_RST;
        end else if (i_gate_open && i_load) begin
            o_count <= i_load_value;
        end else if (i_gate_open && i_event) begin
            o_count <= o_count + 32'h0000_0001;
        end
    end
endmodule

// File: core/interconnect_perf_monitor.sv
`timescale 1ns/1ps
module interconnect_perf_monitor
    import perf_monitor_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic [GLOBAL_EVENTS-1:0] i_global_events,
    input wire logic [GLOBAL_EVENTS-1:0] i_global_secure,
    input wire logic [NUM_SLAVE*SLAVE_EVENTS-1:0] i_slave_events,
    input wire logic [NUM_SLAVE*SLAVE_EVENTS-1:0] i_slave_secure,
    input wire logic [NUM_MASTER*MASTER_EVENTS-1:0] i_master_events,
    input wire logic [NUM_MASTER*MASTER_EVENTS-1:0] i_master_secure,
    input wire logic i_invasive_dbg_en,
    input wire logic i_noninvasive_dbg_en,
    input wire logic i_secure_invasive_dbg_en,
    input wire logic i_secure_noninvasive_dbg_en,
    input wire reg_req_t i_reg_req,
    output logic [DATA_W-1:0] o_rdata,
    output logic [EVENT_W-1:0] o_event_vector,
    output logic [NUM_COUNTERS-1:0] o_counter_overflow_n
);
    // ****************************************************************
    // Debug authentication synchronisers
    // ****************************************************************
    logic [3:0] dbg_meta;
    logic [3:0] dbg_sync;
    logic count_allowed;
    logic secure_allowed;

    // Debug pins come from outside the clock domain
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            dbg_meta <= 4'h0;
            dbg_sync <= 4'h0;
        end else begin
            dbg_meta <= {i_secure_noninvasive_dbg_en, i_secure_invasive_dbg_en,
                         i_noninvasive_dbg_en, i_invasive_dbg_en};
            dbg_sync <= dbg_meta;
        end
    end

    assign count_allowed = dbg_sync[0] | dbg_sync[1];
    assign secure_allowed = dbg_sync[3] | (dbg_sync[0] & dbg_sync[2]);

    // ****************************************************************
    // Event qualification and export
    // ****************************************************************
    logic [EVENT_W-1:0] raw_events;
    logic [EVENT_W-1:0] raw_secure;
    logic [EVENT_W-1:0] exempt_mask;
    logic [EVENT_W-1:0] next_event_vector;

    // Global events sit in the low bits whatever the interface count
    assign raw_events = {i_master_events, i_slave_events,
                         i_global_events};
    assign raw_secure = {i_master_secure, i_slave_secure,
                         i_global_secure};
    assign exempt_mask = {{NUM_MASTER{MASTER_EXEMPT}},
                          {NUM_SLAVE{SLAVE_EXEMPT}},
                          GLOBAL_EXEMPT};

    // Each source bit drives its own position, no remapping
    assign next_event_vector = count_allowed ?
        (raw_events & (exempt_mask | ~raw_secure |
                       {EVENT_W{secure_allowed}})) :
        {EVENT_W{1'b0}};

    // Registered export; counters see the same qualified view
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_event_vector <= {EVENT_W{1'b0}};
        end else begin
            o_event_vector <= next_event_vector;
        end
    end

    // ****************************************************************
    // Register decode
    // ****************************************************************
    logic monitor_enable;
    logic ns_access;
    logic mon_secure_only;
    logic is_counter_page;
    logic [2:0] page_idx;
    logic [3:0] page_ofs;
    logic mon_ok;
    logic sys_ok;
    logic wr_mon;
    logic wr_ctrl;
    logic clear_all;
    logic [NUM_COUNTERS-1:0] ovf_flags;

    assign is_counter_page = (i_reg_req.addr[11:8] == OFS_COUNTER_PAGE) &&
                             !i_reg_req.addr[7] &&
                             (i_reg_req.addr[1:0] == 2'b00);
    assign page_idx = i_reg_req.addr[6:4];
    assign page_ofs = i_reg_req.addr[3:0];
    // Monitor registers open to all unless locked to secure
    assign mon_ok = i_reg_req.secure || !mon_secure_only;
    // Debug status register secure-only until software opens it
    assign sys_ok = i_reg_req.secure || ns_access;
    assign wr_mon = i_reg_req.wr && mon_ok;
    assign wr_ctrl = wr_mon && (i_reg_req.addr == OFS_MONITOR_CONTROL);
    assign clear_all = wr_ctrl && i_reg_req.wdata[CTRL_RESET_BIT];

    // Global enable; the reset bit is a strobe and is not kept
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            monitor_enable <= MONITOR_ENABLE_RST;
        end else if (wr_ctrl) begin
            monitor_enable <= i_reg_req.wdata[CTRL_ENABLE_BIT];
        end
    end

    // Secure access register never opens itself to NS writes
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            ns_access <= NS_ACCESS_RST;
            mon_secure_only <= MON_SECURE_RST;
        end else if (i_reg_req.wr && i_reg_req.secure &&
                     i_reg_req.addr == OFS_SECURE_ACCESS) begin
            ns_access <= i_reg_req.wdata[SA_NS_ACCESS_BIT];
            mon_secure_only <= i_reg_req.wdata[SA_MON_SECURE_BIT];
        end
    end

    // ****************************************************************
    // Counters
    // ****************************************************************
    event_sel_t event_select [NUM_COUNTERS];
    logic [NUM_COUNTERS-1:0] counter_enable;
    logic [CNT_W-1:0] count [NUM_COUNTERS];
    logic [NUM_COUNTERS-1:0] gate_open;
    logic [NUM_COUNTERS-1:0] sel_event;
    logic [NUM_COUNTERS-1:0] count_load;
    logic [NUM_COUNTERS-1:0] wrap;

    // Picks one vector bit; absent or reserved sources yield nothing
    function automatic logic pick_event(input logic [EVENT_W-1:0] vec,
                                        input event_sel_t sel);
        int idx = 0;
        logic hit = 1'b0;
        if (sel.source == SRC_GLOBAL && !sel.code[4]) begin
            idx = int'(sel.code);
            hit = 1'b1;
        end else if (sel.source <= SRC_SLAVE_LAST) begin
            idx = SLAVE_BASE + int'(sel.source) * SLAVE_EVENTS +
                  int'(sel.code);
            hit = 1'b1;
        end else if (sel.source >= SRC_MASTER_BASE &&
                     sel.source <= SRC_MASTER_LAST &&
                     int'(sel.code) < MASTER_EVENTS) begin
            idx = MASTER_BASE +
                  int'(sel.source - SRC_MASTER_BASE) * MASTER_EVENTS +
                  int'(sel.code);
            hit = 1'b1;
        end
        return hit && vec[idx];
    endfunction

    // Only event counters exist; time comes from a system timer
    for (genvar n = 0; n < NUM_COUNTERS; n++) begin : g_cnt
        // Select and enable registers
        always_ff @(posedge i_ref_clk or posedge i_rst) begin
            if (i_rst) begin
                event_select[n] <= EVENT_SELECT_RST;
                counter_enable[n] <= COUNTER_ENABLE_RST;
            end else if (wr_mon && is_counter_page &&
                         page_idx == 3'(n)) begin
                if (page_ofs == OFS_EVENT_SELECT)
                    event_select[n] <= i_reg_req.wdata[8:0];
                if (page_ofs == OFS_COUNTER_CONTROL)
                    counter_enable[n] <=
                        i_reg_req.wdata[CC_ENABLE_BIT];
            end
        end

        // Gated counter freezes while disabled; the global clear still zeroes it
        assign gate_open[n] = monitor_enable && counter_enable[n];
        // At most one selected bit per cycle
        assign sel_event[n] = pick_event(o_event_vector, event_select[n]);
        assign count_load[n] = wr_mon && is_counter_page &&
                               page_idx == 3'(n) &&
                               page_ofs == OFS_EVENT_COUNT;

        event_counter u_counter (
            .i_ref_clk(i_ref_clk),
            .i_rst(i_rst),
            .i_gate_open(gate_open[n]),
            .i_event(sel_event[n]),
            .i_clear(clear_all),
            .i_load(count_load[n]),
            .i_load_value(i_reg_req.wdata),
            .o_count(count[n]),
            .o_wrap(wrap[n])
        );
    end

    // ****************************************************************
    // Overflow flags and pins
    // ****************************************************************
    logic [NUM_COUNTERS-1:0] ovf_clear;

    assign ovf_clear = (wr_mon && i_reg_req.addr == OFS_OVERFLOW_STATUS) ?
                       i_reg_req.wdata[NUM_COUNTERS-1:0] :
                       {NUM_COUNTERS{1'b0}};

    // Sticky flags; a wrap in the clearing cycle still wins
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            ovf_flags <= {NUM_COUNTERS{1'b0}};
        end else begin
            ovf_flags <= (ovf_flags & ~ovf_clear) | wrap;
        end
    end

    // Active-low pins follow the flags one cycle behind
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_counter_overflow_n <= {NUM_COUNTERS{1'b1}};
        end else begin
            o_counter_overflow_n <= ~ovf_flags;
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    logic [DATA_W-1:0] next_rdata;

    // Blocked or unmapped reads return zero, never an error
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (is_counter_page && mon_ok) begin
            case (page_ofs)
                OFS_EVENT_SELECT:
                    next_rdata = {23'h000000, event_select[page_idx]};
                OFS_EVENT_COUNT: next_rdata = count[page_idx];
                OFS_COUNTER_CONTROL:
                    next_rdata = {31'h0, counter_enable[page_idx]};
                default: next_rdata = 32'h0000_0000;
            endcase
        end else begin
            case (i_reg_req.addr)
                OFS_MONITOR_CONTROL:
                    if (mon_ok) next_rdata = {31'h0, monitor_enable};
                OFS_OVERFLOW_STATUS:
                    if (mon_ok) next_rdata = {24'h000000, ovf_flags};
                OFS_SECURE_ACCESS:
                    if (i_reg_req.secure)
                        next_rdata = {30'h0, mon_secure_only, ns_access};
                OFS_DEBUG_STATUS:
                    if (sys_ok)
                        next_rdata = {26'h0, secure_allowed,
                                      count_allowed, dbg_sync};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    // Data stand only in the cycle after the read strobe
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= 32'h0000_0000;
        end else begin
            o_rdata <= i_reg_req.rd ? next_rdata : 32'h0000_0000;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_back_inval_export;
        @(posedge i_ref_clk) disable iff (i_rst)
        (i_global_events[EV_BACK_INVAL] && !i_global_secure[EV_BACK_INVAL]
         && count_allowed) |=> o_event_vector[EV_BACK_INVAL];
    endproperty
    a_back_inval_export: assert property (p_back_inval_export)
        else $error("back-invalidation not exported");
    property p_ways_full_exempt;
        @(posedge i_ref_clk) disable iff (i_rst)
        (i_global_events[EV_SF_WAYS_FULL] && count_allowed)
        |=> o_event_vector[EV_SF_WAYS_FULL];
    endproperty
    a_ways_full_exempt: assert property (p_ways_full_exempt)
        else $error("exempt ways-full event dropped");
    property p_snoop_data_exempt;
        @(posedge i_ref_clk) disable iff (i_rst)
        (i_global_events[EV_SNOOP_DATA] && count_allowed)
        |=> o_event_vector[EV_SNOOP_DATA];
    endproperty
    a_snoop_data_exempt: assert property (p_snoop_data_exempt)
        else $error("snoop data event dropped");
    property p_secure_blocked;
        @(posedge i_ref_clk) disable iff (i_rst)
        (i_global_secure[EV_SF_ANY_BASE] && !secure_allowed)
        |=> !o_event_vector[EV_SF_ANY_BASE];
    endproperty
    a_secure_blocked: assert property (p_secure_blocked)
        else $error("secure event leaked without permission");
    property p_no_debug_no_events;
        @(posedge i_ref_clk) disable iff (i_rst)
        !count_allowed |=> (o_event_vector == {EVENT_W{1'b0}});
    endproperty
    a_no_debug_no_events: assert property (p_no_debug_no_events)
        else $error("events exported while debug disabled");
    property p_count_step;
        @(posedge i_ref_clk) disable iff (i_rst)
        (gate_open[0] && sel_event[0] && !clear_all && !count_load[0])
        |=> (count[0] == $past(count[0]) + 32'h0000_0001);
    endproperty
    a_count_step: assert property (p_count_step)
        else $error("counter 0 did not step by one");
    property p_frozen_when_off;
        @(posedge i_ref_clk) disable iff (i_rst)
        (!gate_open[0] && !clear_all) |=> $stable(count[0]);
    endproperty
    a_frozen_when_off: assert property (p_frozen_when_off)
        else $error("disabled counter 0 changed");
    property p_clear_all;
        @(posedge i_ref_clk) disable iff (i_rst)
        clear_all |=> (count[0] == COUNT_RST && count[7] == COUNT_RST);
    endproperty
    a_clear_all: assert property (p_clear_all)
        else $error("global reset did not clear counters");
    property p_wrap_flag_pin;
        @(posedge i_ref_clk) disable iff (i_rst)
        wrap[0] |=> (ovf_flags[0] && count[0] == COUNT_RST)
                    ##1 !o_counter_overflow_n[0];
    endproperty
    a_wrap_flag_pin: assert property (p_wrap_flag_pin)
        else $error("overflow not flagged and wrapped");
    property p_ns_read_zero;
        @(posedge i_ref_clk) disable iff (i_rst)
        (i_reg_req.rd && !i_reg_req.secure && !ns_access &&
         i_reg_req.addr == OFS_DEBUG_STATUS) |=> (o_rdata == 32'h0);
    endproperty
    a_ns_read_zero: assert property (p_ns_read_zero)
        else $error("non-secure read returned data");
endmodule

// File: core/perf_monitor_pkg.sv
package perf_monitor_pkg;
    // ****************************************************************
    // Sizes
    // ****************************************************************
    localparam int NUM_COUNTERS = 8;
    localparam int CNT_W = 32;
    localparam int NUM_SLAVE = 7;
    localparam int NUM_MASTER = 6;
    localparam int GLOBAL_EVENTS = 16;
    localparam int SLAVE_EVENTS = 32;
    localparam int MASTER_EVENTS = 7;
    localparam int SLAVE_BASE = GLOBAL_EVENTS;
    localparam int MASTER_BASE = SLAVE_BASE + NUM_SLAVE * SLAVE_EVENTS;
    localparam int EVENT_W = MASTER_BASE + NUM_MASTER * MASTER_EVENTS;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // ****************************************************************
    // Global event positions on the exported vector
    // ****************************************************************
    localparam int EV_SF_ANY_BASE = 0;
    localparam int EV_SF_MISS_BASE = 4;
    localparam int EV_BACK_INVAL = 8;
    localparam int EV_SF_WAYS_FULL = 9;
    localparam int EV_TRACKER_FULL = 10;
    localparam int EV_GEN_WRITE = 11;
    localparam int EV_SNOOP_DATA = 12;
    localparam int EV_ADDR_HAZARD = 13;
    localparam int EV_SNOOP_TRACKER_FULL = 14;
    localparam int EV_SNOOP_OVERRIDE = 15;

    // Events without security classification
    localparam logic [GLOBAL_EVENTS-1:0] GLOBAL_EXEMPT = 16'hD200;
    localparam logic [SLAVE_EVENTS-1:0] SLAVE_EXEMPT = 32'h2D44_0300;
    localparam logic [MASTER_EVENTS-1:0] MASTER_EXEMPT = 7'h6B;

    // Source identifiers
    localparam logic [3:0] SRC_SLAVE_LAST = 4'h6;
    localparam logic [3:0] SRC_MASTER_BASE = 4'h8;
    localparam logic [3:0] SRC_MASTER_LAST = 4'hD;
    localparam logic [3:0] SRC_GLOBAL = 4'hF;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [ADDR_W-1:0] OFS_MONITOR_CONTROL = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_SECURE_ACCESS = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_DEBUG_STATUS = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_OVERFLOW_STATUS = 12'h00C;
    localparam logic [3:0] OFS_COUNTER_PAGE = 4'h1;
    localparam logic [3:0] OFS_EVENT_SELECT = 4'h0;
    localparam logic [3:0] OFS_EVENT_COUNT = 4'h4;
    localparam logic [3:0] OFS_COUNTER_CONTROL = 4'h8;

    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_RESET_BIT = 1;
    localparam int SA_NS_ACCESS_BIT = 0;
    localparam int SA_MON_SECURE_BIT = 1;
    localparam int CC_ENABLE_BIT = 0;
    localparam int SEL_CODE_LSB = 0;
    localparam int SEL_SRC_LSB = 5;

    localparam logic MONITOR_ENABLE_RST = 1'b0;
    localparam logic NS_ACCESS_RST = 1'b0;
    localparam logic MON_SECURE_RST = 1'b0;
    localparam logic COUNTER_ENABLE_RST = 1'b0;
    localparam logic [8:0] EVENT_SELECT_RST = 9'h000;
    localparam logic [CNT_W-1:0] COUNT_RST = 32'h0000_0000;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
        logic secure;
    } reg_req_t;

    typedef struct packed {
        logic [3:0] source;
        logic [4:0] code;
    } event_sel_t;
endpackage

// File: dv/event_partner.sv
`timescale 1ns/1ps
module event_partner
    import perf_monitor_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic [GLOBAL_EVENTS-1:0] i_fire,
    input wire logic i_secure,
    output logic [GLOBAL_EVENTS-1:0] o_events,
    output logic [GLOBAL_EVENTS-1:0] o_secure
);
    // Registered pulses; qualifier only rides with a pulse, never stale
    always_ff @(posedge i_ref_clk) begin
        o_events <= i_fire;
        o_secure <= i_secure ? i_fire : '0;
    end
endmodule

// File: dv/tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin \
    $display("FAIL %0t got %h exp %h", $time, a, b); err_total++; end end
module tb;
    import perf_monitor_pkg::*;
    // ************************************************************
    // Stimulus and observation
    // ************************************************************
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [15:0] fire = 16'h0000;
    logic fire_sec = 1'b0;
    logic [3:0] dbg = 4'h0;
    reg_req_t req = '0;
    logic [15:0] gev;
    logic [15:0] gsec;
    // Interface event lanes, driven straight from the bench
    logic [NUM_SLAVE*SLAVE_EVENTS-1:0] sev = '0;
    logic [NUM_SLAVE*SLAVE_EVENTS-1:0] ssec = '0;
    logic [NUM_MASTER*MASTER_EVENTS-1:0] mev = '0;
    logic [NUM_MASTER*MASTER_EVENTS-1:0] msec = '0;
    logic [DATA_W-1:0] o_rdata;
    logic [DATA_W-1:0] rdv;
    logic [EVENT_W-1:0] o_event_vector;
    logic [7:0] o_counter_overflow_n;
    int err_total = 0;
    int num_checks = 0;
    int cycles = 0;

    event_partner event_partner_i (.i_ref_clk(i_ref_clk), .i_fire(fire),
        .i_secure(fire_sec), .o_events(gev), .o_secure(gsec));
    interconnect_perf_monitor interconnect_perf_monitor_i (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_global_events(gev),
        .i_global_secure(gsec), .i_slave_events(sev), .i_slave_secure(ssec),
        .i_master_events(mev), .i_master_secure(msec),
        .i_invasive_dbg_en(dbg[0]), .i_noninvasive_dbg_en(dbg[1]),
        .i_secure_invasive_dbg_en(dbg[2]),
        .i_secure_noninvasive_dbg_en(dbg[3]), .i_reg_req(req),
        .o_rdata(o_rdata), .o_event_vector(o_event_vector),
        .o_counter_overflow_n(o_counter_overflow_n));

    // Free-running clock, 8 ns period
    initial begin
        forever #4 i_ref_clk = ~i_ref_clk;
    end
    // Hang guard; the whole sequence needs about 140 cycles
    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            final_report();
        end
    end

    task automatic final_report();
        if (err_total == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // One-cycle strobes, then an idle cycle so no signal is set twice
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0, secure: 1'b1};
        @(posedge i_ref_clk);
        req <= '0;
    endtask
    task automatic rd(input logic [11:0] a, input logic s);
        @(posedge i_ref_clk);
        req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1, secure: s};
        @(posedge i_ref_clk);
        req <= '0;
        #1 rdv = o_rdata;
    endtask
    // Vector bit shows two edges after the tb raises fire
    task automatic pulse(input logic [15:0] m, input logic s);
        @(posedge i_ref_clk);
        fire <= m;
        fire_sec <= s;
        @(posedge i_ref_clk);
        fire <= 16'h0000;
        @(posedge i_ref_clk);
        #1;
    endtask

    task automatic t_reset();
        #1 `CHK(o_counter_overflow_n, 8'hFF)
        `CHK(o_event_vector, '0)
    endtask
    task automatic t_export();
        pulse(16'h0100, 1'b0);
        `CHK(o_event_vector, '0)
        @(posedge i_ref_clk) dbg <= 4'h2;
        repeat (3) @(posedge i_ref_clk);
        for (int i = 0; i < 16; i++) begin
            pulse(16'h0001 << i, 1'b0);
            `CHK(o_event_vector, EVENT_W'(16'h0001 << i))
        end
        pulse(16'h0101, 1'b1);
        `CHK(o_event_vector, '0)
        pulse(16'h0200, 1'b1);
        `CHK(o_event_vector, EVENT_W'(16'h0200))
        @(posedge i_ref_clk) dbg <= 4'hA;
        repeat (3) @(posedge i_ref_clk);
        pulse(16'h1100, 1'b1);
        `CHK(o_event_vector, EVENT_W'(16'h1100))
        @(posedge i_ref_clk) dbg <= 4'h2;
        repeat (3) @(posedge i_ref_clk);
    endtask
    task automatic t_count();
        wr(12'h100, 32'h0000_01E8);
        wr(12'h108, 32'h0000_0001);
        wr(12'h000, 32'h0000_0001);
        pulse(16'h0100, 1'b0);
        pulse(16'h0100, 1'b0);
        rd(12'h104, 1'b1);
        `CHK(rdv, 32'h0000_0002)
        wr(12'h000, 32'h0000_0003);
        rd(12'h104, 1'b1);
        `CHK(rdv, 32'h0000_0000)
    endtask
    task automatic t_overflow();
        wr(12'h104, 32'hFFFF_FFFF);
        pulse(16'h0100, 1'b0);
        rd(12'h104, 1'b1);
        `CHK(rdv, 32'h0000_0000)
        rd(12'h00C, 1'b1);
        `CHK(rdv, 32'h0000_0001)
        `CHK(o_counter_overflow_n, 8'hFE)
        wr(12'h00C, 32'h0000_0001);
        rd(12'h00C, 1'b1);
        `CHK(rdv, 32'h0000_0000)
        `CHK(o_counter_overflow_n, 8'hFF)
    endtask
    // Slave 1 and master 1 events, plain first, then with Secure set
    task automatic t_ifaces();
        logic [EVENT_W-1:0] exp_vec;
        wr(12'h110, 32'h0000_0023);
        wr(12'h118, 32'h0000_0001);
        wr(12'h120, 32'h0000_0122);
        wr(12'h128, 32'h0000_0001);
        @(posedge i_ref_clk);
        sev <= 224'h1 << (SLAVE_EVENTS + 3);
        mev <= 42'h1 << (MASTER_EVENTS + 2);
        @(posedge i_ref_clk);
        sev <= sev | (224'h1 << (SLAVE_EVENTS + 8));
        ssec <= sev | (224'h1 << (SLAVE_EVENTS + 8));
        mev <= mev | (42'h1 << MASTER_EVENTS);
        msec <= mev | (42'h1 << MASTER_EVENTS);
        exp_vec = '0;
        exp_vec[SLAVE_BASE + SLAVE_EVENTS + 3] = 1'b1;
        exp_vec[MASTER_BASE + MASTER_EVENTS + 2] = 1'b1;
        #1 `CHK(o_event_vector, exp_vec)
        @(posedge i_ref_clk);
        sev <= '0;
        ssec <= '0;
        mev <= '0;
        msec <= '0;
        // Secure plain codes are blocked, exempt codes still pass
        exp_vec = '0;
        exp_vec[SLAVE_BASE + SLAVE_EVENTS + 8] = 1'b1;
        exp_vec[MASTER_BASE + MASTER_EVENTS] = 1'b1;
        #1 `CHK(o_event_vector, exp_vec)
        rd(12'h114, 1'b1);
        `CHK(rdv, 32'h0000_0001)
        rd(12'h124, 1'b1);
        `CHK(rdv, 32'h0000_0001)
    endtask
    // Secure-only default, then opened, then monitor pages locked
    task automatic t_access();
        rd(12'h008, 1'b0);
        `CHK(rdv, 32'h0000_0000)
        rd(12'hFF0, 1'b1);
        `CHK(rdv, 32'h0000_0000)
        wr(12'h004, 32'h0000_0001);
        rd(12'h008, 1'b0);
        `CHK(rdv, 32'h0000_0012)
        wr(12'h004, 32'h0000_0002);
        rd(12'h100, 1'b0);
        `CHK(rdv, 32'h0000_0000)
        rd(12'h100, 1'b1);
        `CHK(rdv, 32'h0000_01E8)
    endtask

    initial begin
        repeat (5) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        t_reset();
        t_export();
        t_count();
        t_overflow();
        t_ifaces();
        t_access();
        final_report();
    end
endmodule
